// *** system_handler_priority_bank.sv ***
// Priority storage for system handlers 4 to 6 behind a plain register
// port, with a registered per-exception priority lookup.
// Assumes one clock mclk, synchronous active-low rst_n, and a master
// that never issues read and write strobes together.
// Fixed priorities of exceptions 1 to 3 appear only as a lookup flag;
// their levels belong to whatever arbitrates between pending handlers.
// A narrower PRIO_W keeps the upper bits of each byte and zeroes the rest.
//
// Overview of operation
// - Priority field for handler n governs exception n, also in the lookup.
// - Exceptions 1 to 3 report fixed priority and have no stored field.
// - Lowest configurable field belongs to exception 4, memory fault.
// - No register for handlers 0 to 3; group zero reads zero.
// - Group one priorities for handlers 4 to 6 are writable and readable.
// - Byte, aligned halfword and word accesses to group one are accepted.
// - Handler 4 priority lives in bits 7 down to 0.
// - Handler 5 priority lives in bits 15 down to 8.
// - Handler 6 priority lives in bits 23 down to 16.
// - Bits 31 down to 24 are reserved for handler 7, no function.
`default_nettype none

module system_handler_priority_bank #(
   parameter int unsigned PRIO_W = 8
) (
   // Clock and synchronous reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port, one access per strobe
   input wire logic [11:0] reg_addr,
   input wire logic [1:0] reg_size,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic reg_error,
   // Priority lookup for the arbitration logic
   input wire logic [3:0] query_exception,
   input wire logic query_valid,
   output logic [7:0] query_priority,
   output logic query_fixed,
   output logic query_configurable,
   output logic query_ready,
   // Live priority fields
   output logic [7:0] memory_fault_priority,
   output logic [7:0] bus_error_priority,
   output logic [7:0] usage_error_priority
);

   // ------------------------------------------------------------------
   // Local types
   // ------------------------------------------------------------------

   // Whole state of the bank in one packed struct
   typedef struct packed {
      logic [7:0] memory_fault_priority;
      logic [7:0] bus_error_priority;
      logic [7:0] usage_error_priority;
      logic [31:0] rdata;
      logic error;
      logic [7:0] query_priority;
      logic query_fixed;
      logic query_configurable;
      logic query_ready;
   } bank_state_t;

   // Answer of the per-exception lookup
   typedef struct packed {
      logic [7:0] priority_value;
      logic fixed;
      logic configurable;
   } lookup_t;

   // ------------------------------------------------------------------
   // Derived constants
   // ------------------------------------------------------------------

   // Stored bits of each priority byte; a narrower build drops the low
   // bits, which then read as zero rather than echo what was written
   localparam logic [7:0] PRIO_KEEP = 8'(8'hFF << (8 - PRIO_W));

   // ------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------

   // Keep only the implemented upper priority bits; low bits read zero
   function automatic logic [7:0] trim_priority(input logic [7:0] value);
      return value & PRIO_KEEP;
   endfunction

   // Merge one byte lane: new data only when its lane is selected
   function automatic logic [7:0] merge_lane(
      input logic [7:0] old_value,
      input logic [31:0] wdata,
      input logic [3:0] mask,
      input logic [1:0] lane
   );
      logic [7:0] new_value;
      new_value = wdata[{lane, 3'h0} +: 8];
      // An unselected lane keeps its value, so narrow writes spare neighbours
      if (mask[lane]) begin
         return trim_priority(new_value);
      end
      return old_value;
   endfunction

   // Word image of group one from the stored fields
   function automatic logic [31:0] group_one_word(input bank_state_t s);
      logic [31:0] word;
      word = handler_priority_pkg::READ_ZERO;
      word[handler_priority_pkg::MEM_FAULT_LSB +: 8] = s.memory_fault_priority;
      word[handler_priority_pkg::BUS_ERROR_LSB +: 8] = s.bus_error_priority;
      word[handler_priority_pkg::USAGE_ERROR_LSB +: 8] = s.usage_error_priority;
      // Lane 3 stays zero: the reserved slot has no storage
      return word;
   endfunction

   // Priority lookup by exception number
   function automatic lookup_t lookup(input bank_state_t s, input logic [3:0] exc);
      lookup_t l;
      l.priority_value = handler_priority_pkg::RESET_PRIORITY;
      l.fixed = 1'b0;
      l.configurable = 1'b0;
      // Handler n answers for exception n; nothing is renumbered
      unique case (exc)
         handler_priority_pkg::EXC_RESET,
         handler_priority_pkg::EXC_NMI,
         handler_priority_pkg::EXC_ESCALATED: begin
            l.fixed = 1'b1;
         end
         handler_priority_pkg::EXC_MEM_FAULT: begin
            l.priority_value = s.memory_fault_priority;
            l.configurable = 1'b1;
         end
         handler_priority_pkg::EXC_BUS_ERROR: begin
            l.priority_value = s.bus_error_priority;
            l.configurable = 1'b1;
         end
         handler_priority_pkg::EXC_USAGE_ERROR: begin
            l.priority_value = s.usage_error_priority;
            l.configurable = 1'b1;
         end
         default: begin
            // Exception 0, the reserved handler 7 and numbers served elsewhere
            l.configurable = 1'b0;
         end
      endcase
      return l;
   endfunction

   // Access the port cannot honour: bad size or alignment, or a word address
   // outside groups zero and one; one decision serves reads and writes alike
   function automatic logic access_refused(
      input logic is_misaligned,
      input logic at_group_zero,
      input logic at_group_one
   );
      logic unmapped;
      unmapped = !at_group_zero && !at_group_one;
      return is_misaligned || unmapped;
   endfunction

   // ------------------------------------------------------------------
   // Address and lane decode
   // ------------------------------------------------------------------

   logic [3:0] lane_mask;
   logic misaligned;
   logic [11:0] word_addr;
   logic hit_group_zero;
   logic hit_group_one;
   logic write_lanes_ok;
   logic access_seen;
   logic access_bad;

   // One decoder serves reads and writes, so both follow one alignment rule
   lane_select u_lane_select (
      .addr_low(reg_addr[1:0]),
      .size(reg_size),
      .lane_mask(lane_mask),
      .misaligned(misaligned)
   );

   // Word address ignores the lane bits so narrow accesses find the word
   assign word_addr = {reg_addr[11:2], 2'h0};
   assign hit_group_zero = (word_addr == handler_priority_pkg::OFFSET_GROUP_ZERO);
   assign hit_group_one = (word_addr == handler_priority_pkg::OFFSET_GROUP_ONE);
   assign write_lanes_ok = reg_write && hit_group_one && !misaligned;

   // ------------------------------------------------------------------
   // Access qualifiers
   // ------------------------------------------------------------------

   // Either strobe; the master never raises both in one cycle
   assign access_seen = reg_write || reg_read;
   // Refused reads still complete and refused writes store nothing; the error pulse flags both
   assign access_bad = access_seen && access_refused(misaligned, hit_group_zero,
      hit_group_one);

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------

   bank_state_t state_reg;
   bank_state_t state_next;
   lookup_t lookup_now;

   always_comb begin
      state_next = state_reg;
      lookup_now = lookup(state_reg, query_exception);

      // Read data stand for one cycle only, then return to zero
      state_next.rdata = handler_priority_pkg::READ_ZERO;
      state_next.error = 1'b0;
      state_next.query_ready = 1'b0;

      // Misaligned writes never get here, so a bad size cannot half-land
      // Writes touch only selected lanes of group one
      if (write_lanes_ok) begin
         state_next.memory_fault_priority = merge_lane(
            state_reg.memory_fault_priority, reg_wdata, lane_mask,
            handler_priority_pkg::LANE_MEM_FAULT);
         state_next.bus_error_priority = merge_lane(
            state_reg.bus_error_priority, reg_wdata, lane_mask,
            handler_priority_pkg::LANE_BUS_ERROR);
         state_next.usage_error_priority = merge_lane(
            state_reg.usage_error_priority, reg_wdata, lane_mask,
            handler_priority_pkg::LANE_USAGE_ERROR);
         // Lane 3 is reserved: write ignored, nothing stored
      end

      // Group zero is not implemented: writes vanish, reads give zero
      if (reg_read) begin
         if (hit_group_one) begin
            state_next.rdata = group_one_word(state_reg);
         end else begin
            state_next.rdata = handler_priority_pkg::READ_ZERO;
         end
      end

      // Flag accesses that cannot be honoured; data path is unaffected
      if (access_bad) begin
         state_next.error = 1'b1;
      end

      // A write in the same cycle is not seen: the lookup reads state_reg
      // Lookup answers one cycle after the query, held until the next one
      if (query_valid) begin
         state_next.query_priority = lookup_now.priority_value;
         state_next.query_fixed = lookup_now.fixed;
         state_next.query_configurable = lookup_now.configurable;
         state_next.query_ready = 1'b1;
      end

      // Synchronous reset: every field to its constant
      // Placed last so that reset wins over an access in the same cycle
      if (!rst_n) begin
         state_next.memory_fault_priority = handler_priority_pkg::RESET_PRIORITY;
         state_next.bus_error_priority = handler_priority_pkg::RESET_PRIORITY;
         state_next.usage_error_priority = handler_priority_pkg::RESET_PRIORITY;
         state_next.rdata = handler_priority_pkg::READ_ZERO;
         state_next.error = 1'b0;
         state_next.query_priority = handler_priority_pkg::RESET_PRIORITY;
         state_next.query_fixed = 1'b0;
         state_next.query_configurable = 1'b0;
         state_next.query_ready = 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------

   // Reset is folded into state_next, so this stays a plain register
   // with no enable and no reset branch of its own
   always_ff @(posedge mclk) begin
      state_reg <= state_next;
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------

   // Register port answers; every output is a flop, so none glitches
   assign reg_rdata = state_reg.rdata;
   assign reg_error = state_reg.error;

   // Lookup answers
   assign query_priority = state_reg.query_priority;
   assign query_fixed = state_reg.query_fixed;
   assign query_configurable = state_reg.query_configurable;
   assign query_ready = state_reg.query_ready;

   // Live fields for the arbiter
   assign memory_fault_priority = state_reg.memory_fault_priority;
   assign bus_error_priority = state_reg.bus_error_priority;
   assign usage_error_priority = state_reg.usage_error_priority;

endmodule

`default_nettype wire

// *** handler_priority_pkg.sv ***
// Constants for the system handler priority bank: offsets, field layout,
// exception numbers, access sizes and reset values.
// Assumes a 32-bit register word and a byte-addressed register port.
`default_nettype none

package handler_priority_pkg;

   // ------------------------------------------------------------------
   // Register port geometry
   // ------------------------------------------------------------------
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned LANES = 4;
   localparam int unsigned LANE_W = 8;

   // ------------------------------------------------------------------
   // Register offsets (byte addresses, word aligned)
   // ------------------------------------------------------------------
   localparam logic [11:0] OFFSET_GROUP_ZERO = 12'h000;
   localparam logic [11:0] OFFSET_GROUP_ONE = 12'h004;

   // ------------------------------------------------------------------
   // Field positions inside handler_priority_group_one
   // ------------------------------------------------------------------
   localparam int unsigned MEM_FAULT_LSB = 0;
   localparam int unsigned BUS_ERROR_LSB = 8;
   localparam int unsigned USAGE_ERROR_LSB = 16;
   localparam int unsigned SEVEN_RESERVED_LSB = 24;
   localparam logic [1:0] LANE_MEM_FAULT = 2'h0;
   localparam logic [1:0] LANE_BUS_ERROR = 2'h1;
   localparam logic [1:0] LANE_USAGE_ERROR = 2'h2;
   localparam logic [1:0] LANE_SEVEN_RESERVED = 2'h3;

   // ------------------------------------------------------------------
   // Exception numbers; handler n is served by field n
   // ------------------------------------------------------------------
   localparam logic [3:0] EXC_UNDEFINED = 4'h0;
   localparam logic [3:0] EXC_RESET = 4'h1;
   localparam logic [3:0] EXC_NMI = 4'h2;
   localparam logic [3:0] EXC_ESCALATED = 4'h3;
   localparam logic [3:0] EXC_MEM_FAULT = 4'h4;
   localparam logic [3:0] EXC_BUS_ERROR = 4'h5;
   localparam logic [3:0] EXC_USAGE_ERROR = 4'h6;
   localparam logic [3:0] EXC_SEVEN = 4'h7;

   // ------------------------------------------------------------------
   // Access sizes on the register port
   // ------------------------------------------------------------------
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // ------------------------------------------------------------------
   // Reset and fill values
   // ------------------------------------------------------------------
   localparam logic [7:0] RESET_PRIORITY = 8'h00;
   localparam logic [31:0] READ_ZERO = 32'h00000000;
   localparam logic [3:0] NO_LANES = 4'h0;

endpackage

`default_nettype wire

// *** lane_select.sv ***
// Byte lane decoder for the register port: turns the low address bits
// and the access size into a lane mask.
// Assumes sizes from handler_priority_pkg; purely combinational.
`default_nettype none

module lane_select (
   input wire logic [1:0] addr_low,
   input wire logic [1:0] size,
   output logic [3:0] lane_mask,
   output logic misaligned
);

   // ------------------------------------------------------------------
   // Mask decode
   // ------------------------------------------------------------------

   // Misaligned or unknown sizes give no lanes so nothing gets written
   always_comb begin
      lane_mask = handler_priority_pkg::NO_LANES;
      misaligned = 1'b0;
      unique case (size)
         handler_priority_pkg::SIZE_BYTE: begin
            lane_mask = 4'h1 << addr_low;
         end
         handler_priority_pkg::SIZE_HALF: begin
            if (addr_low[0]) begin
               misaligned = 1'b1;
            end else if (addr_low[1]) begin
               lane_mask = 4'hC;
            end else begin
               lane_mask = 4'h3;
            end
         end
         handler_priority_pkg::SIZE_WORD: begin
            if (addr_low != 2'h0) begin
               misaligned = 1'b1;
            end else begin
               lane_mask = 4'hF;
            end
         end
         default: begin
            misaligned = 1'b1;
         end
      endcase
   end

endmodule

`default_nettype wire

// *** system_handler_priority_bank_asserts.sv ***
// Checker for the handler priority bank: read, write and lookup timing.
// Assumes one clock domain and a master that never raises both strobes.
`default_nettype none

module system_handler_priority_bank_asserts #(
   parameter int unsigned PRIO_W = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [11:0] reg_addr,
   input wire logic [1:0] reg_size,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_error,
   input wire logic [3:0] query_exception,
   input wire logic query_valid,
   input wire logic [7:0] query_priority,
   input wire logic query_fixed,
   input wire logic query_configurable,
   input wire logic query_ready,
   input wire logic [7:0] memory_fault_priority,
   input wire logic [7:0] bus_error_priority,
   input wire logic [7:0] usage_error_priority
);
   // ----------------------------------------------------------------
   // Properties, all on mclk and quiet during reset
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
      else $error("read data not idle");
   a_read_word: assert property (
      reg_read && reg_addr == 12'h004 |=>
      reg_rdata == {8'h00, usage_error_priority, bus_error_priority, memory_fault_priority})
      else $error("read word does not match fields");
   // Group zero answers zero; only an illegal size raises the error pulse
   a_group_zero: assert property (reg_read && reg_addr == 12'h000 |=>
      reg_rdata == 32'h0 && reg_error == ($past(reg_size) == 2'h3))
      else $error("group zero not empty");
   a_error_idle: assert property (!(reg_read || reg_write) |=> !reg_error)
      else $error("error without access");
   // Anything but a write to group one must leave every field alone
   a_fields_hold: assert property (
      !(reg_write && reg_addr[11:2] == 10'h001) |=>
      $stable(memory_fault_priority) && $stable(bus_error_priority)
      && $stable(usage_error_priority)) else $error("field changed without write");
   a_byte_lane: assert property (
      reg_write && reg_size == 2'h0 && reg_addr == 12'h005 |=>
      bus_error_priority == $past(reg_wdata[15:8]) && $stable(memory_fault_priority)
      && $stable(usage_error_priority)) else $error("byte write hit wrong lane");
   a_bad_size: assert property (reg_write && reg_size == 2'h3 |=> reg_error
      && $stable(memory_fault_priority) && $stable(bus_error_priority))
      else $error("illegal size accepted");
   a_query_ready: assert property (1'b1 |=> query_ready == $past(query_valid))
      else $error("lookup ready misplaced");
   a_fixed_flag: assert property (
      query_valid && query_exception inside {4'h1, 4'h2, 4'h3} |=>
      query_fixed && !query_configurable && query_priority == 8'h00)
      else $error("fixed exception misreported");
   a_bus_query: assert property (
      query_valid && query_exception == 4'h5 && !reg_write |=>
      query_configurable && !query_fixed && query_priority == bus_error_priority)
      else $error("bus error lookup wrong");
   a_mem_query: assert property (
      query_valid && query_exception == 4'h4 && !reg_write |=>
      query_configurable && !query_fixed && query_priority == memory_fault_priority)
      else $error("memory fault lookup wrong");
   // The answer is a snapshot: it holds until the next query
   a_query_hold: assert property (!query_valid |=> $stable(query_priority)
      && $stable(query_fixed) && $stable(query_configurable))
      else $error("lookup answer moved without query");
endmodule

bind system_handler_priority_bank system_handler_priority_bank_asserts #(.PRIO_W(PRIO_W))
   u_asserts (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_size(reg_size),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .reg_error(reg_error), .query_exception(query_exception),
   .query_valid(query_valid), .query_priority(query_priority), .query_fixed(query_fixed),
   .query_configurable(query_configurable), .query_ready(query_ready),
   .memory_fault_priority(memory_fault_priority), .bus_error_priority(bus_error_priority),
   .usage_error_priority(usage_error_priority));

`default_nettype wire

// *** system_handler_priority_bank_tb.sv ***
// Self-checking bench for the handler priority bank: register port and lookup.
// Assumes a one-cycle read latency and reset value 0 for every field.
`default_nettype none

module system_handler_priority_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, reg_write, reg_read, query_valid;
   logic query_fixed, query_configurable, query_ready, reg_error;
   logic [11:0] reg_addr;
   logic [1:0] reg_size;
   logic [31:0] reg_wdata, reg_rdata, model;
   logic [3:0] query_exception;
   logic [7:0] query_priority, memory_fault_priority, bus_error_priority, usage_error_priority;
   int n_errors = 0;
   int samples_checked = 0;

   system_handler_priority_bank #(.PRIO_W(8)) u_dut (.mclk(mclk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_size(reg_size), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .reg_error(reg_error), .query_exception(query_exception), .query_valid(query_valid),
      .query_priority(query_priority), .query_fixed(query_fixed),
      .query_configurable(query_configurable), .query_ready(query_ready),
      .memory_fault_priority(memory_fault_priority),
      .bus_error_priority(bus_error_priority), .usage_error_priority(usage_error_priority));

   // ----------------------------------------------------------------
   // Clock, watchdog and closing report
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Cuts a hang short after 50000 cycles, far above the roughly 90 a full run takes
   initial begin
      #400000;
      n_errors++;
      wrap_up();
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Compare and access tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_fields;
      chk("memory fault", {24'h0, model[7:0]}, {24'h0, memory_fault_priority});
      chk("bus error", {24'h0, model[15:8]}, {24'h0, bus_error_priority});
      chk("usage error", {24'h0, model[23:16]}, {24'h0, usage_error_priority});
   endtask

   // Misaligned halfword or word, or the unused size code
   function automatic logic bad_acc(input logic [11:0] a, input logic [1:0] s);
      return s == 2'h3 || (s == 2'h1 && a[0]) || (s == 2'h2 && a[1:0] != 2'h0);
   endfunction

   task automatic wr(input logic [11:0] a, input logic [1:0] s, input logic [31:0] d);
      @(posedge mclk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_size <= s;
      reg_wdata <= d;
      @(posedge mclk);
      reg_write <= 1'b0;
      // Lane 3 is reserved, so the model never takes it
      if (a[11:2] == 10'h001 && !bad_acc(a, s)) begin
         for (int k = 0; k < 3; k++) begin
            if (s == 2'h2 || (s == 2'h1 && k[1] == a[1]) || k == int'(a[1:0])) begin
               model[8*k +: 8] = d[8*k +: 8];
            end
         end
      end
      #1;
      chk("write error", {31'h0, bad_acc(a, s) || a[11:3] != 9'h0},
         {31'h0, reg_error});
      chk_fields();
   endtask

   task automatic rd(input logic [11:0] a, input logic [1:0] s);
      @(posedge mclk);
      reg_read <= 1'b1;
      reg_addr <= a;
      reg_size <= s;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1;
      chk("read data", (a[11:2] == 10'h001) ? model : 32'h0, reg_rdata);
      chk("read error", {31'h0, bad_acc(a, s) || a[11:3] != 9'h0},
         {31'h0, reg_error});
   endtask

   task automatic qry(input logic [3:0] e);
      logic [7:0] p;
      p = (e == 4'h4) ? model[7:0] : (e == 4'h5) ? model[15:8] :
          (e == 4'h6) ? model[23:16] : 8'h00;
      @(posedge mclk);
      query_valid <= 1'b1;
      query_exception <= e;
      @(posedge mclk);
      query_valid <= 1'b0;
      #1;
      chk("query ready", 32'h1, {31'h0, query_ready});
      chk("query priority", {24'h0, p}, {24'h0, query_priority});
      chk("query fixed", {31'h0, e inside {4'h1, 4'h2, 4'h3}},
         {31'h0, query_fixed});
      chk("query config", {31'h0, e inside {4'h4, 4'h5, 4'h6}},
         {31'h0, query_configurable});
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 12'h000;
      reg_size = 2'h0;
      reg_wdata = 32'h0;
      query_valid = 1'b0;
      query_exception = 4'h0;
      model = 32'h0;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk_fields();
      rd(12'h004, 2'h2);
      wr(12'h004, 2'h2, 32'hAA332211);
      rd(12'h004, 2'h2);
      // Same byte in every lane, so a stray lane shows up at once
      for (int k = 0; k < 4; k++) begin
         wr(12'h004 + 12'(k), 2'h0, {4{8'h40 + 8'(k)}});
         rd(12'h004 + 12'(k), 2'h0);
      end
      wr(12'h006, 2'h1, 32'h5A6B7C8D);
      rd(12'h006, 2'h1);
      wr(12'h004, 2'h1, 32'h1234C3D4);
      wr(12'h005, 2'h1, 32'hFFFFFFFF);
      wr(12'h006, 2'h2, 32'hFFFFFFFF);
      wr(12'h004, 2'h3, 32'hFFFFFFFF);
      rd(12'h007, 2'h1);
      wr(12'h000, 2'h2, 32'hFFFFFFFF);
      rd(12'h000, 2'h2);
      wr(12'h008, 2'h2, 32'hFFFFFFFF);
      rd(12'h008, 2'h2);
      for (int e = 0; e < 16; e++) begin
         qry(4'(e));
      end
      // Reset in mid-run must clear every stored field
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      model = 32'h0;
      #1;
      chk_fields();
      rd(12'h004, 2'h2);
      wrap_up();
   end
endmodule

`default_nettype wire
